/* osc_pkg.sv */
package osc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ctl_two_addr = 8'h00;
	localparam logic [7:0] ctl_one_addr = 8'h04;
	localparam logic [7:0] cfg_addr = 8'h08;
	localparam logic [7:0] sleep_addr = 8'h0c;
	localparam logic [7:0] irq_status_addr = 8'h10;
	localparam logic [7:0] irq_enable_addr = 8'h14;
	localparam logic [7:0] irq_clear_addr = 8'h18;
	localparam logic [7:0] wait_status_addr = 8'h1c;

	// ****************************************
	// control two field positions
	// ****************************************
	localparam int multiplier_running_bit = 7;
	localparam int aux_running_bit = 6;
	localparam int mid_sub_bit = 4;
	localparam int aux_start_bit = 3;
	localparam int drive_on_bit = 2;
	localparam int mid_stable_bit = 1;
	localparam int low_stable_bit = 0;
	localparam logic [7:0] ctl_two_write_mask = 8'h1c;
	localparam logic [7:0] ctl_two_reset = 8'h04;

	// ****************************************
	// interrupt event bits
	// ****************************************
	localparam int ev_wait_done = 0;
	localparam int ev_clock_switched = 1;
	localparam int ev_mid_stable = 2;
	localparam int ev_low_stable = 3;
	localparam int event_count = 4;

	// ****************************************
	// timing
	// ****************************************
	localparam int crystal_wait_oscillations = 1024;
	localparam int multiplier_extra_ms = 2;
	localparam longint clk_hz = 250000000;
	localparam int multiplier_extra_cycles = int'((longint'(multiplier_extra_ms) * clk_hz) / 1000);
	localparam int ext_resume_instr_cycles = 2;
	localparam int instr_clk_div = 4;
	localparam int switch_settle_cycles = 4;
	localparam int int_osc_start_cycles = 8;

	// ****************************************
	// encodings
	// ****************************************
	typedef enum logic [2:0] {
		outside_clock_mode,
		low_gain_crystal_mode,
		mid_gain_crystal_mode,
		high_gain_crystal_mode,
		resistor_cap_mode,
		internal_osc_mode
	} clock_class_e;

	// clock pick field: 00 primary, 01 aux, 1x internal block
	localparam logic [1:0] pick_primary = 2'b00;
	localparam logic [1:0] pick_aux = 2'b01;

	typedef enum logic [1:0] {
		src_fast,
		src_mid,
		src_slow
	} int_src_e;

	// oscillator stability inputs grouped
	typedef struct packed {
		logic mid_ready;
		logic low_ready;
		logic fast_ready;
		logic aux_ready;
	} osc_ready_s;

	// clock routing outputs grouped
	typedef struct packed {
		logic [1:0] sel_source;
		logic use_multiplier;
		logic [2:0] int_div_sel;
		int_src_e int_src;
	} clk_route_s;

endpackage

/* osc_status_startup.sv */
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

module osc_status_startup #(
	parameter int crystal_count = osc_pkg::crystal_wait_oscillations,
	parameter int multiplier_cycles = osc_pkg::multiplier_extra_cycles
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// oscillator side
	input wire logic primary_osc_edge,
	input wire osc_pkg::osc_ready_s osc_ready,
	input wire logic aux_other_request,
	input wire logic power_on_event,
	input wire logic power_up_timer_done,
	input wire logic wake_event,
	// outputs
	output logic primary_drive_en,
	output logic aux_osc_en,
	output osc_pkg::clk_route_s clk_route,
	output logic cpu_hold,
	output logic irq
);

	// ****************************************
	// state
	// ****************************************
	typedef enum {st_idle, st_por_wait, st_count, st_extra, st_int_start, st_settle, st_resume} wait_e;

	logic [7:0] ctl_two;
	logic [7:0] next_ctl_two;
	logic [7:0] ctl_one;
	logic [7:0] next_ctl_one;
	logic [7:0] cfg;
	logic [7:0] next_cfg;
	logic [3:0] irq_status;
	logic [3:0] next_irq_status;
	logic [3:0] irq_enable;
	logic [3:0] next_irq_enable;
	wait_e wstate;
	wait_e next_wstate;
	logic [31:0] wcount;
	logic [31:0] next_wcount;
	logic [1:0] active_pick;
	logic [1:0] next_active_pick;
	logic aw_hold, next_aw_hold, w_hold, next_w_hold;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic [1:0] div_cnt, next_div_cnt;
	logic mid_q, low_q;
	logic do_write, do_read, wait_done, switched;
	logic [7:0] status_view;

	// cfg: [2:0] clock class, [3] two-speed, [4] multiplier enable
	function automatic logic is_crystal(input logic [2:0] c);
		return c == osc_pkg::low_gain_crystal_mode || c == osc_pkg::mid_gain_crystal_mode ||
			c == osc_pkg::high_gain_crystal_mode;
	endfunction

	// only byte lane 0 carries register bits
	function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
		lane = old;
		if (s[0]) begin
			lane = d[7:0];
		end
	endfunction

	// ****************************************
	// status view of control two
	// ****************************************
	always_comb begin
		status_view = ctl_two & osc_pkg::ctl_two_write_mask;
		status_view[osc_pkg::multiplier_running_bit] = cfg[4] && active_pick == osc_pkg::pick_primary &&
			!cpu_hold;
		status_view[osc_pkg::aux_running_bit] = active_pick == osc_pkg::pick_aux;
		status_view[osc_pkg::mid_stable_bit] = osc_ready.mid_ready;
		status_view[osc_pkg::low_stable_bit] = osc_ready.low_ready;
	end

	// ****************************************
	// axi4-lite slave
	// ****************************************
	assign s_axi_awready = !aw_hold && !bvalid;
	assign s_axi_wready = !w_hold && !bvalid;
	assign s_axi_arready = !rvalid;
	assign do_write = (aw_hold || s_axi_awvalid) && (w_hold || s_axi_wvalid) && !bvalid;
	assign do_read = s_axi_arvalid && !rvalid;

	// bus channel bookkeeping
	always_comb begin
		next_aw_hold = aw_hold;
		next_w_hold = w_hold;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			case ((aw_hold ? aw_addr : s_axi_awaddr) & 8'hfc)
				osc_pkg::ctl_two_addr, osc_pkg::ctl_one_addr, osc_pkg::cfg_addr, osc_pkg::sleep_addr,
				osc_pkg::irq_status_addr, osc_pkg::irq_enable_addr, osc_pkg::irq_clear_addr,
				osc_pkg::wait_status_addr: next_bresp = 2'b00;
				default: next_bresp = 2'b10;
			endcase
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (do_read) begin
			next_rvalid = 1'b1;
			next_rresp = 2'b00;
			case (s_axi_araddr & 8'hfc)
				osc_pkg::ctl_two_addr: next_rdata = {24'h00_0000, status_view};
				osc_pkg::ctl_one_addr: next_rdata = {24'h00_0000, ctl_one};
				osc_pkg::cfg_addr: next_rdata = {24'h00_0000, cfg};
				osc_pkg::irq_status_addr: next_rdata = {28'h000_0000, irq_status};
				osc_pkg::irq_enable_addr: next_rdata = {28'h000_0000, irq_enable};
				osc_pkg::wait_status_addr: next_rdata = {29'h0000_0000, cpu_hold, active_pick};
				osc_pkg::sleep_addr, osc_pkg::irq_clear_addr: next_rdata = 32'h0000_0000;
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = 2'b10;
				end
			endcase
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// ****************************************
	// software registers and interrupts
	// ****************************************
	always_comb begin
		logic [7:0] wa;
		logic [31:0] wd;
		logic [3:0] ws;
		wa = (aw_hold ? aw_addr : s_axi_awaddr) & 8'hfc;
		wd = w_hold ? w_data : s_axi_wdata;
		ws = w_hold ? w_strb : s_axi_wstrb;
		next_ctl_two = ctl_two;
		next_ctl_one = ctl_one;
		next_cfg = cfg;
		next_irq_enable = irq_enable;
		next_irq_status = irq_status;
		if (do_write) begin
			case (wa)
				osc_pkg::ctl_two_addr: next_ctl_two = lane(ctl_two, wd, ws) &
					osc_pkg::ctl_two_write_mask;
				osc_pkg::ctl_one_addr: next_ctl_one = lane(ctl_one, wd, ws);
				osc_pkg::cfg_addr: next_cfg = lane(cfg, wd, ws);
				osc_pkg::irq_enable_addr: next_irq_enable = 4'(lane({4'h0, irq_enable}, wd, ws));
				osc_pkg::irq_clear_addr: next_irq_status = irq_status & ~4'(lane(8'h00, wd, ws));
				default: ;
			endcase
		end
		// events set after clear so a coincident event wins
		if (wait_done) begin
			next_irq_status[osc_pkg::ev_wait_done] = 1'b1;
		end
		if (switched) begin
			next_irq_status[osc_pkg::ev_clock_switched] = 1'b1;
		end
		if (osc_ready.mid_ready && !mid_q) begin
			next_irq_status[osc_pkg::ev_mid_stable] = 1'b1;
		end
		if (osc_ready.low_ready && !low_q) begin
			next_irq_status[osc_pkg::ev_low_stable] = 1'b1;
		end
	end

	// ****************************************
	// start-up wait sequencer
	// ****************************************
	always_comb begin
		logic sleep_wr;
		logic [2:0] cls;
		sleep_wr = do_write && ((aw_hold ? aw_addr : s_axi_awaddr) & 8'hfc) == osc_pkg::sleep_addr;
		cls = cfg[2:0];
		next_wstate = wstate;
		next_wcount = wcount;
		next_active_pick = active_pick;
		next_div_cnt = div_cnt + 2'd1;
		wait_done = 1'b0;
		switched = 1'b0;
		case (wstate)
			st_idle: begin
				if (power_on_event) begin
					next_wstate = st_por_wait;
				end else if (wake_event || sleep_wr) begin
					next_wstate = st_count;
					next_wcount = 32'd0;
				end else if (ctl_one[1:0] != active_pick) begin
					next_wstate = st_settle;
					next_wcount = 32'd0;
				end
			end
			st_por_wait: begin
				if (power_up_timer_done) begin
					next_wstate = st_count;
					next_wcount = 32'd0;
				end
			end
			st_count: begin
				if (cls == osc_pkg::outside_clock_mode) begin
					next_wstate = st_idle;
					wait_done = 1'b1;
				end else if (cls == osc_pkg::resistor_cap_mode) begin
					next_wstate = st_resume;
					next_wcount = 32'd0;
				end else if (cls == osc_pkg::internal_osc_mode) begin
					next_wstate = st_int_start;
					next_wcount = 32'd0;
				end else if (primary_osc_edge) begin
					next_wcount = wcount + 32'd1;
					if (wcount == 32'(crystal_count - 1)) begin
						next_wcount = 32'd0;
						if (cfg[4]) begin
							next_wstate = st_extra;
						end else begin
							next_wstate = st_idle;
							wait_done = 1'b1;
						end
					end
				end
			end
			st_extra: begin
				next_wcount = wcount + 32'd1;
				if (wcount == 32'(multiplier_cycles - 1)) begin
					next_wstate = st_idle;
					wait_done = 1'b1;
				end
			end
			st_int_start, st_settle: begin
				next_wcount = wcount + 32'd1;
				if (wcount == 32'((wstate == st_settle ? osc_pkg::switch_settle_cycles :
					osc_pkg::int_osc_start_cycles) - 1)) begin
					next_wstate = st_idle;
					if (wstate == st_settle) begin
						next_active_pick = ctl_one[1:0];
						switched = 1'b1;
					end else begin
						wait_done = 1'b1;
					end
				end
			end
			st_resume: begin
				if (div_cnt == 2'd3) begin
					next_wcount = wcount + 32'd1;
					if (wcount == 32'(osc_pkg::ext_resume_instr_cycles - 1)) begin
						next_wstate = st_idle;
						wait_done = 1'b1;
					end
				end
			end
			default: next_wstate = st_idle;
		endcase
	end

	// ****************************************
	// outputs
	// ****************************************
	always_comb begin
		logic two_speed_run;
		two_speed_run = cfg[3] && is_crystal(cfg[2:0]) && (wstate == st_count || wstate == st_extra);
		cpu_hold = wstate != st_idle && !two_speed_run;
		primary_drive_en = ctl_two[osc_pkg::drive_on_bit];
		aux_osc_en = ctl_two[osc_pkg::aux_start_bit] || aux_other_request;
		clk_route.sel_source = two_speed_run ? 2'b10 : active_pick;
		clk_route.use_multiplier = cfg[4] && !cpu_hold;
		clk_route.int_div_sel = ctl_one[6:4];
		// fast 16M by default; low choices from mid when substituted
		if (ctl_one[6:4] == 3'd0) begin
			clk_route.int_src = osc_pkg::src_slow;
		end else begin
			clk_route.int_src = osc_pkg::src_fast;
		end
		if (ctl_two[osc_pkg::mid_sub_bit] && ctl_one[6:4] <= 3'd2) begin
			clk_route.int_src = osc_pkg::src_mid;
		end
		irq = |(irq_status & irq_enable);
	end

	// register all state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_two <= osc_pkg::ctl_two_reset;
			ctl_one <= 8'h30;
			cfg <= 8'h00;
			irq_status <= 4'h0;
			irq_enable <= 4'h0;
			wstate <= st_idle;
			wcount <= 32'd0;
			active_pick <= osc_pkg::pick_primary;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'b00;
			rvalid <= 1'b0;
			rresp <= 2'b00;
			rdata <= 32'h0000_0000;
			div_cnt <= 2'd0;
			mid_q <= 1'b0;
			low_q <= 1'b0;
		end else begin
			ctl_two <= next_ctl_two;
			ctl_one <= next_ctl_one;
			cfg <= next_cfg;
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			wstate <= next_wstate;
			wcount <= next_wcount;
			active_pick <= next_active_pick;
			aw_hold <= next_aw_hold;
			w_hold <= next_w_hold;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			div_cnt <= next_div_cnt;
			mid_q <= osc_ready.mid_ready;
			low_q <= osc_ready.low_ready;
		end
	end

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;

	// ****************************************
	// assertions
	// ****************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_drive_gate: assert property (primary_drive_en == ctl_two[2]) else $error("drive gate wrong");
	a_aux_request: assert property (aux_other_request |-> aux_osc_en) else $error("aux stopped");
	a_bit5_zero: assert property (!status_view[5]) else $error("bit5 set");
	a_aux_flag: assert property (status_view[6] == (active_pick == 2'b01)) else $error("aux flag");
	a_hold_count: assert property (wstate == st_count && !cfg[3] |-> cpu_hold) else $error("no hold");
	a_ec_bypass: assert property (wstate == st_count && cfg[2:0] == 3'd0 |=> wstate == st_idle)
		else $error("ec wait");
	a_crystal_step: assert property (wstate == st_count && is_crystal(cfg[2:0]) && primary_osc_edge
		&& wcount < 32'(crystal_count - 1) |=> wcount == $past(wcount) + 32'd1) else $error("count");
	a_switch_settle: assert property (wstate == st_idle && !power_on_event && !wake_event && !do_write
		&& ctl_one[1:0] != active_pick |=> wstate == st_settle [*4] ##1 active_pick == $past(ctl_one[1:0]))
		else $error("settle");
	a_mid_stable: assert property (status_view[1] == osc_ready.mid_ready) else $error("mid flag");

	c_por_wait: cover property (wstate == st_por_wait ##1 wstate == st_count);
	c_multiplier: cover property (wstate == st_extra);
	c_switch: cover property (switched);
	c_irq: cover property (irq);

endmodule

/* osc_partner.sv */
`timescale 1ns/1ps

// ****************************************
// crystal and internal oscillator model
// ****************************************
module osc_partner (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control from the block and the bench
	input wire logic primary_drive_en,
	input wire logic slow,
	input wire logic mid_level,
	input wire logic low_level,
	// oscillator side
	output logic primary_osc_edge,
	output osc_pkg::osc_ready_s osc_ready
);
	logic [2:0] phase;

	// one pulse per oscillation; a dead drive circuit gives no pulses at all
	always_ff @(posedge aclk) begin
		if (!aresetn || !primary_drive_en) begin
			phase <= 3'h0;
			primary_osc_edge <= 1'b0;
		end else begin
			phase <= (phase == (slow ? 3'h6 : 3'h2)) ? 3'h0 : phase + 3'h1;
			primary_osc_edge <= (phase == 3'h0);
		end
	end

	// stability levels: mid, low, fast, aux
	assign osc_ready = {mid_level, low_level, 1'b1, primary_drive_en};
endmodule

/* oscillator_status_and_startup_bench.sv */
`timescale 1ns/1ps

// ****************************************
// register and start-up bench
// ****************************************
module oscillator_status_and_startup_bench;
	localparam int cc = 8;
	localparam int mc = 16;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, d;
	logic [1:0] r;
	logic primary_osc_edge, primary_drive_en, aux_osc_en, cpu_hold, irq;
	logic aux_other_request = 1'b0, power_on_event = 1'b0, power_up_timer_done = 1'b1, wake_event = 1'b0;
	logic slow = 1'b0, mid_level = 1'b0, low_level = 1'b1;
	osc_pkg::osc_ready_s osc_ready;
	osc_pkg::clk_route_s clk_route;
	int num_errors = 0, n_tests = 0, hcyc, hedg, tail, i, n;

	osc_status_startup #(.crystal_count(cc), .multiplier_cycles(mc)) osc_status_startup_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.primary_osc_edge, .osc_ready, .aux_other_request, .power_on_event, .power_up_timer_done,
		.wake_event, .primary_drive_en, .aux_osc_en, .clk_route, .cpu_hold, .irq);
	osc_partner osc_partner_inst (.aclk, .aresetn, .primary_drive_en, .slow, .mid_level, .low_level,
		.primary_osc_edge, .osc_ready);

	// 250 MHz clock
	always #2 aclk = ~aclk;

	// measure each hold: cycles, oscillations, cycles after the last counted oscillation
	always @(negedge aclk) begin
		if (cpu_hold === 1'b1) begin
			hcyc++;
			tail++;
			if (primary_osc_edge === 1'b1) begin
				hedg++;
				if (hedg == cc) tail = 0;
			end
		end
	end

	task automatic final_report();
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a, d, r);
		chk(d, exp);
	endtask

	// change the clock pick, see the old pick during settling, then the new one
	task automatic pick(input logic [31:0] v, input logic [1:0] old, input logic [31:0] two);
		wr(osc_pkg::irq_clear_addr, 32'h0000_000f);
		wr(osc_pkg::ctl_one_addr, v);
		rd(osc_pkg::wait_status_addr, d, r);
		chk(d[1:0], old);
		for (n = 0; n < 50 && d[1:0] !== v[1:0]; n++) rd(osc_pkg::wait_status_addr, d, r);
		chk(d[1:0], v[1:0]);
		rc(osc_pkg::irq_status_addr, 32'h0000_0002);
		wr(osc_pkg::irq_clear_addr, 32'h0000_000f);
		rc(osc_pkg::ctl_two_addr, two);
	endtask

	// set the clock class, trigger a wake or a sleep write and wait for the hold to end
	task automatic start_up(input logic [31:0] cfg, input logic w);
		wr(osc_pkg::irq_clear_addr, 32'h0000_000f);
		wr(osc_pkg::cfg_addr, cfg);
		hcyc = 0;
		hedg = 0;
		tail = 0;
		if (w) begin
			wake_event <= 1'b1;
			@(posedge aclk);
			wake_event <= 1'b0;
		end else begin
			wr(osc_pkg::sleep_addr, 32'h0000_0001);
		end
		repeat (3) @(negedge aclk);
		for (n = 0; n < 5000 && cpu_hold !== 1'b0; n++) @(negedge aclk);
	endtask

	// hang guard
	initial begin
		repeat (60000) @(posedge aclk);
		num_errors++;
		final_report();
	end

	// main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rc(osc_pkg::ctl_two_addr, 32'h0000_0005);
		rd(8'h20, d, r);
		chk(d, 32'h0000_0000);
		chk(32'(r), 32'h0000_0002);
		wr(osc_pkg::ctl_two_addr, 32'h0000_00ff);
		rc(osc_pkg::ctl_two_addr, 32'h0000_001d);
		chk(aux_osc_en, 1'b1);
		wr(osc_pkg::ctl_two_addr, 32'h0000_0000);
		aux_other_request <= 1'b1;
		@(negedge aclk);
		chk({aux_osc_en, primary_drive_en}, 2'b10);
		@(posedge aclk);
		aux_other_request <= 1'b0;
		@(negedge aclk);
		chk(aux_osc_en, 1'b0);
		wr(osc_pkg::irq_clear_addr, 32'h0000_000f);
		wr(osc_pkg::irq_enable_addr, 32'h0000_0004);
		mid_level <= 1'b1;
		repeat (3) @(negedge aclk);
		chk(irq, 1'b1);
		rc(osc_pkg::ctl_two_addr, 32'h0000_0003);
		wr(osc_pkg::irq_clear_addr, 32'h0000_0004);
		@(negedge aclk);
		chk(irq, 1'b0);
		low_level <= 1'b0;
		repeat (3) @(posedge aclk);
		low_level <= 1'b1;
		repeat (3) @(negedge aclk);
		rc(osc_pkg::irq_status_addr, 32'h0000_0008);
		chk(irq, 1'b0);
		wr(osc_pkg::ctl_two_addr, 32'h0000_0004);
		pick(32'h0000_0031, 2'b00, 32'h0000_0047);
		pick(32'h0000_0012, 2'b01, 32'h0000_0007);
		chk(clk_route.int_src, osc_pkg::src_fast);
		wr(osc_pkg::ctl_two_addr, 32'h0000_0014);
		@(negedge aclk);
		chk(clk_route.int_src, osc_pkg::src_mid);
		wr(osc_pkg::ctl_two_addr, 32'h0000_0004);
		pick(32'h0000_0030, 2'b10, 32'h0000_0007);
		wr(osc_pkg::irq_enable_addr, 32'h0000_0001);
		for (i = 1; i < 4; i++) begin
			slow <= (i == 3);
			start_up(i, i == 2);
			chk(hedg, cc);
			chk(irq, 1'b1);
		end
		start_up(32'h0000_0009, 1'b0);
		chk(hcyc < 3 * cc, 1'b1);
		// two-speed wait still counts in the background; let it finish
		repeat (80) @(posedge aclk);
		chk(irq, 1'b1);
		start_up(32'h0000_0011, 1'b0);
		chk(tail, mc);
		chk(tail >= mc && tail <= mc + 2, 1'b1);
		rc(osc_pkg::ctl_two_addr, 32'h0000_0087);
		start_up(32'h0000_0000, 1'b0);
		chk(hcyc <= 2, 1'b1);
		start_up(32'h0000_0004, 1'b1);
		chk(hcyc >= 2 && hcyc <= 12, 1'b1);
		start_up(32'h0000_0005, 1'b0);
		chk(hcyc >= 8 && hcyc <= 10, 1'b1);
		wr(osc_pkg::cfg_addr, 32'h0000_0001);
		power_up_timer_done <= 1'b0;
		power_on_event <= 1'b1;
		@(posedge aclk);
		power_on_event <= 1'b0;
		repeat (30) @(negedge aclk);
		chk(cpu_hold, 1'b1);
		@(posedge aclk);
		power_up_timer_done <= 1'b1;
		// counting starts one edge after the timer is seen done
		@(posedge aclk);
		hedg = 0;
		for (n = 0; n < 5000 && cpu_hold !== 1'b0; n++) @(negedge aclk);
		chk(hedg, cc);
		chk(cpu_hold, 1'b0);
		final_report();
	end
endmodule
